/* shared/osk_pkg.sv */
/*
 oscillator select and unlock key: register map, field positions, reset values, key codes,
 source encoding and the register request carrier.
 assumes the serial interface logic runs on the same clock as the block that imports this.
*/
package osk_pkg;
	localparam logic [7:0] OSK_OFS_CTRL = 8'h1C;
	localparam logic [7:0] OSK_OFS_STAT = 8'h1D;
	localparam logic [7:0] OSK_OFS_KEY = 8'h1F;

	localparam logic [7:0] OSK_RST_CTRL = 8'h00;
	localparam logic [7:0] OSK_RST_STAT = 8'h22;
	localparam logic [7:0] OSK_RST_KEY = 8'h00;

	localparam logic [7:0] OSK_KEY_OSC = 8'hA1;
	localparam logic [7:0] OSK_KEY_SWRST = 8'h3C;
	localparam logic [7:0] OSK_KEY_ANALOG = 8'h9D;

	// writable bits; the rest are reserved
	localparam logic [7:0] OSK_CTRL_WMASK = 8'hFB;

	localparam int unsigned OSK_CTRL_SRC = 7;
	localparam int unsigned OSK_CTRL_CAL_HI = 6;
	localparam int unsigned OSK_CTRL_CAL_LO = 5;
	localparam int unsigned OSK_CTRL_BAT = 4;
	localparam int unsigned OSK_CTRL_FAIL = 3;
	localparam int unsigned OSK_CTRL_OSC_FAIL_IRQ_ENABLE = 1;
	localparam int unsigned OSK_CTRL_CAL_FAIL_IRQ_ENABLE = 0;

	localparam int unsigned OSK_STAT_TRIM_HI = 7;
	localparam int unsigned OSK_STAT_TRIM_LO = 6;
	localparam int unsigned OSK_STAT_LOCK = 5;
	localparam int unsigned OSK_STAT_MODE = 4;
	localparam int unsigned OSK_STAT_OF = 1;
	localparam int unsigned OSK_STAT_ACF = 0;

	typedef enum logic {
		OSK_SRC_XT = 1'b0,
		OSK_SRC_RC = 1'b1
	} osk_src_type;

	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] data;
	} osk_req_type;
endpackage

/* rtl/osk_osc_key.sv */
/*
 oscillator control, oscillator status and unlock key registers with source selection,
 failure flags, interrupt request, trim output and key-gated write enables.
 assumes register requests come from serial interface logic on MCLK; oscillator and power
 indications arrive from other domains and are synchronised here.
*/
`timescale 1ns/100ps
module osk_osc_key (
	input wire logic MCLK,
	input wire logic SYS_RST,
	input wire osk_pkg::osk_req_type REG_REQ,
	output logic [7:0] REG_RDATA,
	input wire logic XT_RUNNING,
	input wire logic ON_BATTERY,
	input wire logic XT_BELOW_8K,
	input wire logic POR_SUPPLY_LOST,
	input wire logic CAL_FAILED,
	input wire logic OUTPUT2_LEVEL_WE,
	input wire logic OUTPUT2_LEVEL_BIT,
	output logic SECOND_OUTPUT_PIN,
	output logic ACTIVE_SOURCE_RC,
	output logic [1:0] CRYSTAL_SLOW_TRIM,
	output logic CAL_START,
	output logic IRQ,
	output logic SW_RESET,
	output logic ANALOG_WR_EN
);
	import osk_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// input synchronisers: run, battery, slow, por, cal fail

	logic [4:0] in_meta_r;
	logic [4:0] in_sync_r;
	logic [4:0] in_prev_r;
	logic xt_run_s;
	logic bat_s;
	logic xt_slow_s;
	logic por_rise;
	logic calf_rise;

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			in_meta_r <= 5'h00;
			in_sync_r <= 5'h00;
			in_prev_r <= 5'h00;
		end else begin
			in_meta_r <= {CAL_FAILED, POR_SUPPLY_LOST, XT_BELOW_8K, ON_BATTERY, XT_RUNNING};
			in_sync_r <= in_meta_r;
			in_prev_r <= in_sync_r;
		end
	end

	assign xt_run_s = in_sync_r[0];
	assign bat_s = in_sync_r[1];
	assign xt_slow_s = in_sync_r[2];
	// edges so a held level counts once; the flag can then be cleared while it stays high
	assign por_rise = in_sync_r[3] & ~in_prev_r[3];
	assign calf_rise = in_sync_r[4] & ~in_prev_r[4];

	////////////////////////////////////////////////////////////////////////////////
	// register access decode

	logic [7:0] ctrl_r;
	logic [7:0] ctrl_nxt;
	logic [7:0] key_r;
	logic [7:0] key_nxt;
	logic [1:0] trim_r;
	logic lock_r;
	logic of_r;
	logic of_nxt;
	logic acf_r;
	logic acf_nxt;
	osk_src_type src_r;
	osk_src_type src_nxt;
	logic wr_ctrl;
	logic wr_stat;
	logic wr_key;
	logic key_osc_ok;
	logic ctrl_accept;
	logic want_rc;
	logic [7:0] stat_view;
	logic [7:0] rdata_nxt;

	// one address compare shared by the write strobes and the read mux
	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
		return addr == ofs;
	endfunction

	assign wr_ctrl = REG_REQ.wr && reg_hit(REG_REQ.addr, OSK_OFS_CTRL);
	assign wr_stat = REG_REQ.wr && reg_hit(REG_REQ.addr, OSK_OFS_STAT);
	assign wr_key = REG_REQ.wr && reg_hit(REG_REQ.addr, OSK_OFS_KEY);
	assign key_osc_ok = (key_r == OSK_KEY_OSC);
	assign ctrl_accept = wr_ctrl && key_osc_ok;

	// reserved bit masked off on the way in
	assign ctrl_nxt = ctrl_accept ? (REG_REQ.data & OSK_CTRL_WMASK) : ctrl_r;

	// 0x3C is the one key write that does not land in the key
	assign key_nxt = wr_key ? ((REG_REQ.data == OSK_KEY_SWRST) ? key_r : REG_REQ.data) :
		(REG_REQ.wr ? OSK_RST_KEY : key_r);

	////////////////////////////////////////////////////////////////////////////////
	// flags: a set in the same cycle as a clear wins

	assign of_nxt = por_rise | xt_slow_s |
		(of_r & ~(wr_stat & ~REG_REQ.data[OSK_STAT_OF]));
	assign acf_nxt = calf_rise | (acf_r & ~(wr_stat & ~REG_REQ.data[OSK_STAT_ACF]));

	////////////////////////////////////////////////////////////////////////////////
	// source selection

	assign want_rc = ctrl_r[OSK_CTRL_SRC] |
		(ctrl_r[OSK_CTRL_BAT] & bat_s) |
		(ctrl_r[OSK_CTRL_FAIL] & of_r);
	// a dead crystal keeps the old source rather than stopping the timers
	assign src_nxt = want_rc ? OSK_SRC_RC : (xt_run_s ? OSK_SRC_XT : src_r);

	////////////////////////////////////////////////////////////////////////////////
	// read data

	assign stat_view = {trim_r, lock_r, src_r == OSK_SRC_RC, 2'h0, of_r, acf_r};
	assign rdata_nxt = reg_hit(REG_REQ.addr, OSK_OFS_CTRL) ? ctrl_r :
		reg_hit(REG_REQ.addr, OSK_OFS_STAT) ? stat_view :
		reg_hit(REG_REQ.addr, OSK_OFS_KEY) ? key_r : 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			ctrl_r <= OSK_RST_CTRL;
			key_r <= OSK_RST_KEY;
			trim_r <= OSK_RST_STAT[OSK_STAT_TRIM_HI:OSK_STAT_TRIM_LO];
			lock_r <= OSK_RST_STAT[OSK_STAT_LOCK];
			of_r <= OSK_RST_STAT[OSK_STAT_OF];
			acf_r <= OSK_RST_STAT[OSK_STAT_ACF];
			src_r <= OSK_SRC_XT;
		end else begin
			ctrl_r <= ctrl_nxt;
			key_r <= key_nxt;
			if (wr_stat) begin
				trim_r <= REG_REQ.data[OSK_STAT_TRIM_HI:OSK_STAT_TRIM_LO];
				lock_r <= REG_REQ.data[OSK_STAT_LOCK];
			end
			of_r <= of_nxt;
			acf_r <= acf_nxt;
			src_r <= src_nxt;
		end
	end

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			SECOND_OUTPUT_PIN <= 1'b0;
		end else if (OUTPUT2_LEVEL_WE && !(OUTPUT2_LEVEL_BIT && lock_r)) begin
			SECOND_OUTPUT_PIN <= OUTPUT2_LEVEL_BIT;
		end
	end

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			REG_RDATA <= 8'h00;
			CAL_START <= 1'b0;
			SW_RESET <= 1'b0;
			IRQ <= 1'b0;
		end else begin
			REG_RDATA <= rdata_nxt;
			CAL_START <= ctrl_accept && (REG_REQ.data[OSK_CTRL_CAL_HI:OSK_CTRL_CAL_LO] != 2'h0);
			SW_RESET <= wr_key && (REG_REQ.data == OSK_KEY_SWRST);
			IRQ <= (of_nxt & ctrl_nxt[OSK_CTRL_OSC_FAIL_IRQ_ENABLE]) |
				(acf_nxt & ctrl_nxt[OSK_CTRL_CAL_FAIL_IRQ_ENABLE]);
		end
	end

	assign ACTIVE_SOURCE_RC = (src_r == OSK_SRC_RC);
	assign CRYSTAL_SLOW_TRIM = trim_r;
	assign ANALOG_WR_EN = (key_r == OSK_KEY_ANALOG);

	////////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking @(posedge MCLK); endclocking
	default disable iff (SYS_RST);

	property p_ctrl_locked;
		wr_ctrl && !key_osc_ok |=> $stable(ctrl_r);
	endproperty
	a_ctrl_locked: assert property (p_ctrl_locked) else $error("locked control write landed");

	property p_ctrl_write;
		ctrl_accept |=> ctrl_r == ($past(REG_REQ.data) & OSK_CTRL_WMASK);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("keyed control write lost");

	property p_cal_start;
		ctrl_accept && REG_REQ.data[OSK_CTRL_CAL_HI:OSK_CTRL_CAL_LO] != 2'h0 |=>
			CAL_START ##1 !CAL_START;
	endproperty
	a_cal_start: assert property (p_cal_start) else $error("calibration start not one pulse");

	property p_key_clear;
		REG_REQ.wr && !wr_key |=> key_r == OSK_RST_KEY;
	endproperty
	a_key_clear: assert property (p_key_clear) else $error("key not cleared by write");

	property p_swrst;
		wr_key && REG_REQ.data == OSK_KEY_SWRST |=> SW_RESET && $stable(key_r);
	endproperty
	a_swrst: assert property (p_swrst) else $error("software reset key mishandled");

	property p_xt_hold;
		src_r == OSK_SRC_RC && !xt_run_s |=> src_r == OSK_SRC_RC;
	endproperty
	a_xt_hold: assert property (p_xt_hold) else $error("switched to stopped crystal");

	property p_bat_rc;
		ctrl_r[OSK_CTRL_BAT] && bat_s |=> ACTIVE_SOURCE_RC;
	endproperty
	a_bat_rc: assert property (p_bat_rc) else $error("no RC on battery");

	property p_of_irq;
		xt_slow_s && ctrl_r[OSK_CTRL_OSC_FAIL_IRQ_ENABLE] && !ctrl_accept |=> of_r && IRQ;
	endproperty
	a_of_irq: assert property (p_of_irq) else $error("slow crystal missed flag or irq");

	property p_lock;
		lock_r && !SECOND_OUTPUT_PIN |=> !SECOND_OUTPUT_PIN;
	endproperty
	a_lock: assert property (p_lock) else $error("locked output went high");

	property p_of_clear;
		wr_stat && !REG_REQ.data[OSK_STAT_OF] && !por_rise && !xt_slow_s |=>
			!of_r ##1 (of_r == ($past(por_rise) || $past(xt_slow_s)));
	endproperty
	a_of_clear: assert property (p_of_clear) else $error("failure flag not cleared");

	property p_rc_request;
		ctrl_r[OSK_CTRL_SRC] |=> src_r == OSK_SRC_RC;
	endproperty
	a_rc_request: assert property (p_rc_request) else $error("RC request ignored");

	property p_xt_request;
		!ctrl_r[OSK_CTRL_SRC] && !ctrl_r[OSK_CTRL_BAT] && !ctrl_r[OSK_CTRL_FAIL] && xt_run_s |=>
			!ACTIVE_SOURCE_RC;
	endproperty
	a_xt_request: assert property (p_xt_request) else $error("crystal request ignored");

	property p_fail_rc;
		ctrl_r[OSK_CTRL_FAIL] && of_r |=> ACTIVE_SOURCE_RC;
	endproperty
	a_fail_rc: assert property (p_fail_rc) else $error("no RC after failure");

	property p_por_set;
		por_rise |=> of_r;
	endproperty
	a_por_set: assert property (p_por_set) else $error("supply loss missed flag");

	property p_acf_set;
		calf_rise |=> acf_r;
	endproperty
	a_acf_set: assert property (p_acf_set) else $error("calibration failure missed");

	property p_acf_irq;
		calf_rise && ctrl_r[OSK_CTRL_CAL_FAIL_IRQ_ENABLE] && !ctrl_accept |=> IRQ;
	endproperty
	a_acf_irq: assert property (p_acf_irq) else $error("calibration failure irq missed");

	property p_mode_read;
		REG_REQ.addr == OSK_OFS_STAT |=> REG_RDATA[OSK_STAT_MODE] == $past(ACTIVE_SOURCE_RC);
	endproperty
	a_mode_read: assert property (p_mode_read) else $error("source bit reads wrong");

	property p_ctrl_reserved;
		REG_REQ.addr == OSK_OFS_CTRL |=> (REG_RDATA & ~OSK_CTRL_WMASK) == 8'h00;
	endproperty
	a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("reserved bit set");

	property p_trim_write;
		wr_stat |=> CRYSTAL_SLOW_TRIM == $past(REG_REQ.data[OSK_STAT_TRIM_HI:OSK_STAT_TRIM_LO]);
	endproperty
	a_trim_write: assert property (p_trim_write) else $error("trim write lost");

	property p_analog;
		wr_key && REG_REQ.data == OSK_KEY_ANALOG |=> ANALOG_WR_EN;
	endproperty
	a_analog: assert property (p_analog) else $error("analog key not honoured");
endmodule

/* sim/osk_host.sv */
/*
 host model: drives register requests into osk_osc_key and reads REG_RDATA back.
 assumes MCLK drives the block; requests launch 1 ns after a rising edge.
*/
`timescale 1ns/100ps
module osk_host (
	input wire logic MCLK,
	output osk_pkg::osk_req_type REG_REQ,
	input wire logic [7:0] REG_RDATA
);
	import osk_pkg::*;
	initial begin
		REG_REQ = '0;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge MCLK);
		#1;
		REG_REQ = '{wr: 1'b1, addr: a, data: d};
		@(posedge MCLK);
		#1;
		// released data must not keep the last value
		REG_REQ = '{wr: 1'b0, addr: a, data: ~d};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge MCLK);
		#1;
		REG_REQ.addr = a;
		@(posedge MCLK);
		#1;
		d = REG_RDATA;
	endtask
	// key write always goes first, any write but the 0x3C key write burns it
	task automatic unlock_wr(input logic [7:0] a, input logic [7:0] d);
		wr(OSK_OFS_KEY, OSK_KEY_OSC);
		wr(a, d);
	endtask
endmodule

/* sim/tb.sv */
/*
 testbench for osk_osc_key: register sequences through the host model.
 assumes the block's assertions live beside its logic in the design file.
*/
`timescale 1ns/100ps
module tb;
	import osk_pkg::*;
	logic MCLK = 0, SYS_RST = 1, xt = 1, bat = 0, low = 0, por = 0, calf = 0;
	logic o2we = 0, o2b = 1, pin, rc, cs, irq, swr, aen;
	logic [1:0] trim;
	logic [7:0] rdata;
	osk_req_type req;
	int fail_count = 0, n_compared = 0, cal_n = 0, sw_n = 0;
	osk_osc_key DUT (.MCLK(MCLK), .SYS_RST(SYS_RST), .REG_REQ(req), .REG_RDATA(rdata),
		.XT_RUNNING(xt), .ON_BATTERY(bat), .XT_BELOW_8K(low), .POR_SUPPLY_LOST(por),
		.CAL_FAILED(calf), .OUTPUT2_LEVEL_WE(o2we), .OUTPUT2_LEVEL_BIT(o2b),
		.SECOND_OUTPUT_PIN(pin), .ACTIVE_SOURCE_RC(rc), .CRYSTAL_SLOW_TRIM(trim),
		.CAL_START(cs), .IRQ(irq), .SW_RESET(swr), .ANALOG_WR_EN(aen));
	osk_host host (.MCLK(MCLK), .REG_REQ(req), .REG_RDATA(rdata));
	initial forever #10 MCLK = ~MCLK;
	// pulses counted so a missed or doubled one shows
	always @(posedge MCLK) begin
		if (cs === 1'b1) cal_n++;
		if (swr === 1'b1) sw_n++;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		n_compared++;
		if (s !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic rg(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		host.rd(a, d);
		chk($sformatf("reg %h", a), d, e);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge MCLK);
		#1;
	endtask
	task automatic conclude;
		if (fail_count == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		tick(6);
		SYS_RST = 0;
		rg(OSK_OFS_CTRL, OSK_RST_CTRL);
		rg(OSK_OFS_STAT, OSK_RST_STAT);
		rg(OSK_OFS_KEY, OSK_RST_KEY);
		host.wr(OSK_OFS_CTRL, 8'hFF);
		rg(OSK_OFS_CTRL, 8'h00);
		host.unlock_wr(OSK_OFS_CTRL, 8'h1F);
		tick(3);
		rg(OSK_OFS_CTRL, 8'h1B);
		rg(OSK_OFS_KEY, 8'h00);
		chk("cal", 8'(cal_n), 8'h00);
		chk("irq", 8'(irq), 8'h01);
		chk("rc", 8'(rc), 8'h01);
		host.wr(OSK_OFS_STAT, 8'hDC);
		tick(3);
		rg(OSK_OFS_STAT, 8'hC0);
		chk("trim", 8'(trim), 8'h03);
		chk("irq", 8'(irq), 8'h00);
		bat = 1;
		tick(5);
		chk("rc", 8'(rc), 8'h01);
		rg(OSK_OFS_STAT, 8'hD0);
		bat = 0;
		calf = 1;
		tick(5);
		chk("rc", 8'(rc), 8'h00);
		chk("irq", 8'(irq), 8'h01);
		rg(OSK_OFS_STAT, 8'hC1);
		calf = 0;
		host.wr(OSK_OFS_STAT, 8'hC0);
		tick(2);
		chk("irq", 8'(irq), 8'h00);
		low = 1;
		tick(5);
		low = 0;
		rg(OSK_OFS_STAT, 8'hD2);
		host.wr(OSK_OFS_STAT, 8'hC0);
		tick(3);
		rg(OSK_OFS_STAT, 8'hC0);
		por = 1;
		tick(5);
		por = 0;
		rg(OSK_OFS_STAT, 8'hD2);
		host.wr(OSK_OFS_STAT, 8'h00);
		xt = 0;
		host.unlock_wr(OSK_OFS_CTRL, 8'hC0);
		tick(3);
		chk("cal", 8'(cal_n), 8'h01);
		chk("rc", 8'(rc), 8'h01);
		host.unlock_wr(OSK_OFS_CTRL, 8'h00);
		tick(5);
		chk("rc", 8'(rc), 8'h01);
		xt = 1;
		tick(5);
		chk("rc", 8'(rc), 8'h00);
		host.wr(OSK_OFS_STAT, 8'h20);
		o2we = 1;
		tick(1);
		o2we = 0;
		tick(2);
		chk("pin", 8'(pin), 8'h00);
		host.wr(OSK_OFS_STAT, 8'h00);
		o2we = 1;
		tick(1);
		o2we = 0;
		tick(2);
		chk("pin", 8'(pin), 8'h01);
		host.wr(OSK_OFS_KEY, OSK_KEY_ANALOG);
		host.wr(OSK_OFS_KEY, OSK_KEY_SWRST);
		tick(2);
		chk("swrst", 8'(sw_n), 8'h01);
		chk("analog", 8'(aen), 8'h01);
		rg(OSK_OFS_KEY, OSK_KEY_ANALOG);
		host.wr(OSK_OFS_STAT, 8'h00);
		tick(2);
		chk("analog", 8'(aen), 8'h00);
		// switches and irq enable all clear: failure and battery must not move the source
		bat = 1;
		low = 1;
		tick(5);
		chk("rc", 8'(rc), 8'h00);
		chk("irq", 8'(irq), 8'h00);
		rg(OSK_OFS_STAT, 8'h02);
		bat = 0;
		low = 0;
		SYS_RST = 1;
		tick(2);
		SYS_RST = 0;
		rg(OSK_OFS_STAT, OSK_RST_STAT);
		chk("irq", 8'(irq), 8'h00);
		conclude();
	end
endmodule
